// *** rtl/sdpc_pkg.sv ***
// Purpose: Shared constants, command set and helpers for the SDRAM pin control
// Assumes: One external bus clock at 10 MHz, synchronous active-high reset
// Notes: Strobe codes are {row, column, write}, all active low
package sdpc_pkg;

  localparam int SDPC_SPACE_HI = 31;
  localparam int SDPC_SPACE_LO = 26;
  localparam logic [5:0] SDPC_SPACE_CODE = 6'h01;
  localparam int SDPC_ADDR_W = 14;
  localparam int SDPC_A10_POS = 10;
  localparam int SDPC_ODD_WORD_POS = 0;

  // Standard command truth table, {row, column, write}
  localparam logic [2:0] SDPC_STB_NOP = 3'h7;
  localparam logic [2:0] SDPC_STB_ACT = 3'h3;
  localparam logic [2:0] SDPC_STB_RD = 3'h5;
  localparam logic [2:0] SDPC_STB_WR = 3'h4;
  localparam logic [2:0] SDPC_STB_PRE = 3'h2;
  localparam logic [2:0] SDPC_STB_REF = 3'h1;
  localparam logic [2:0] SDPC_STB_MRS = 3'h0;

  localparam logic SDPC_SEL_N_RST = 1'b1;
  localparam logic SDPC_MASK_RST = 1'b0;
  localparam logic SDPC_CKE_RST = 1'b1;
  localparam logic SDPC_OE_N_RST = 1'b1;

  typedef enum logic [3:0] {
    SDPC_CMD_NOP,
    SDPC_CMD_ACT,
    SDPC_CMD_RD,
    SDPC_CMD_WR,
    SDPC_CMD_PRE,
    SDPC_CMD_REF,
    SDPC_CMD_MRS,
    SDPC_CMD_SR_ENTER,
    SDPC_CMD_SR_EXIT,
    SDPC_CMD_SUSP_ENTER,
    SDPC_CMD_SUSP_EXIT
  } sdpc_cmd_e;

  function automatic logic sdpc_in_space(input logic [31:0] addr);
    return addr[SDPC_SPACE_HI:SDPC_SPACE_LO] == SDPC_SPACE_CODE;
  endfunction

  // Commands that carry a memory address and so must hit the SDRAM region
  function automatic logic sdpc_needs_region(input sdpc_cmd_e cmd);
    return (cmd == SDPC_CMD_ACT) || (cmd == SDPC_CMD_RD) || (cmd == SDPC_CMD_WR);
  endfunction

  function automatic logic [2:0] sdpc_encode(input sdpc_cmd_e cmd);
    logic [2:0] s;
    s = SDPC_STB_NOP;
    case (cmd)
      SDPC_CMD_ACT: s = SDPC_STB_ACT;
      SDPC_CMD_RD: s = SDPC_STB_RD;
      SDPC_CMD_WR: s = SDPC_STB_WR;
      SDPC_CMD_PRE: s = SDPC_STB_PRE;
      SDPC_CMD_REF: s = SDPC_STB_REF;
      SDPC_CMD_MRS: s = SDPC_STB_MRS;
      SDPC_CMD_SR_ENTER: s = SDPC_STB_REF;
      default: s = SDPC_STB_NOP;
    endcase
    return s;
  endfunction

endpackage

// *** rtl/sdpc_cke_ctrl.sv ***
// Purpose: Clock-enable state for self-refresh and suspend
// Assumes: Commands arrive already accepted, one per cycle
// Notes: A pending bus grant pulls the part out of suspend, never out of self-refresh
module sdpc_cke_ctrl
  import sdpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic take,
  input wire sdpc_pkg::sdpc_cmd_e cmd,
  input wire logic grant_pending,
  output logic cmd_allowed,
  output logic in_self_refresh,
  output logic in_suspend,
  output logic cke_q
);
  typedef enum logic [1:0] {SDPC_CKE_RUN, SDPC_CKE_SELF, SDPC_CKE_SUSP} sdpc_cke_e;

  sdpc_cke_e state_q;
  sdpc_cke_e state_d;
  logic cke_d;

  always_comb
  begin
    state_d = state_q;
    cmd_allowed = 1'b0;
    case (state_q)
      SDPC_CKE_RUN:
      begin
        cmd_allowed = (cmd != SDPC_CMD_SR_EXIT) && (cmd != SDPC_CMD_SUSP_EXIT);
        if (take && cmd == SDPC_CMD_SR_ENTER)
          state_d = SDPC_CKE_SELF;
        else if (take && cmd == SDPC_CMD_SUSP_ENTER && !grant_pending)
          state_d = SDPC_CKE_SUSP;
      end
      SDPC_CKE_SELF:
      begin
        cmd_allowed = (cmd == SDPC_CMD_SR_EXIT);
        if (take && cmd == SDPC_CMD_SR_EXIT)
          state_d = SDPC_CKE_RUN;
      end
      SDPC_CKE_SUSP:
      begin
        cmd_allowed = (cmd == SDPC_CMD_SUSP_EXIT);
        // Handing the bus over with a suspended part would strand it
        if ((take && cmd == SDPC_CMD_SUSP_EXIT) || grant_pending)
          state_d = SDPC_CKE_RUN;
      end
      default: state_d = SDPC_CKE_RUN;
    endcase
    cke_d = (state_d == SDPC_CKE_RUN);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= SDPC_CKE_RUN;
      cke_q <= SDPC_CKE_RST;
    end
    else
    begin
      state_q <= state_d;
      cke_q <= cke_d;
    end
  end

  assign in_self_refresh = (state_q == SDPC_CKE_SELF);
  assign in_suspend = (state_q == SDPC_CKE_SUSP);

endmodule // sdpc_cke_ctrl

// *** rtl/sdpc_pin_control.sv ***
// Purpose: Pin-level command, mask and clock-enable logic toward external SDRAM
// Assumes: Requests and mastership come from logic on the same external bus clock
// Notes: One command per accepted request that is not dropped, presented for one cycle, then a NOP if no other follows
//
// How it works
// - The space select goes low for every command cycle, and accesses must decode to 0b000001.
// - Only while this device is bus master are the pins driven; otherwise they float.
// - The row strobe goes low in the very cycle the row address is on the address lines.
// - The column strobe goes low in the very cycle the column address is on the address lines.
// - Refresh, precharge and mode set follow the standard strobe truth table.
// - With the column strobe low, the write strobe is low for writes and high for reads.
// - Masks only matter with the column strobe low, and both stay inactive on reads.
// - A word write to an odd address on a 64-bit bus raises the low mask.
// - A word write to an even address, or any write on a 32-bit bus, raises the high mask.
// - Address bit 10 has its own pin, so refresh leaves the shared address bus free.
// - Clock enable takes the part into and out of self-refresh and suspend.
// - Before a grant clock enable rests high, or low if the part is in self-refresh.
module sdpc_pin_control
  import sdpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic is_bus_master,
  input wire logic grant_pending,
  input wire logic bus_is_32bit,
  input wire logic req_valid,
  output logic req_ready,
  input wire sdpc_pkg::sdpc_cmd_e req_cmd,
  input wire logic [31:0] req_addr,
  input wire logic [sdpc_pkg::SDPC_ADDR_W-1:0] req_sdram_addr,
  input wire logic req_long,
  output logic req_dropped,
  output logic grant_safe,
  output logic sdram_space_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic sdram_write_strobe_n,
  output logic low_word_data_mask,
  output logic high_word_data_mask,
  output logic dedicated_row_addr_bit10,
  output logic [sdpc_pkg::SDPC_ADDR_W-1:0] sdram_addr,
  output logic sdram_addr_oe_n,
  output logic cmd_pins_oe_n,
  output logic sdram_clock_enable_out,
  output logic cke_oe_n
);
  import sdpc_pkg::*;

  logic take;
  logic region_ok;
  logic issue;
  logic cmd_allowed;
  logic in_self_refresh;
  logic in_suspend;
  logic cke_q;
  logic is_write;
  logic odd_word;

  logic sel_n_q;
  logic sel_n_d;
  logic [2:0] stb_q;
  logic [2:0] stb_d;
  logic low_word_data_mask_q;
  logic low_word_data_mask_d;
  logic high_word_data_mask_q;
  logic high_word_data_mask_d;
  logic a10_q;
  logic a10_d;
  logic [SDPC_ADDR_W-1:0] addr_q;
  logic [SDPC_ADDR_W-1:0] addr_d;
  logic addr_oe_n_q;
  logic addr_oe_n_d;
  logic cmd_oe_n_q;
  logic cmd_oe_n_d;
  logic cke_oe_n_q;
  logic cke_oe_n_d;
  logic drop_q;
  logic drop_d;

  sdpc_cke_ctrl u_cke (
    .clk(clk),
    .reset(reset),
    .take(take),
    .cmd(req_cmd),
    .grant_pending(grant_pending),
    .cmd_allowed(cmd_allowed),
    .in_self_refresh(in_self_refresh),
    .in_suspend(in_suspend),
    .cke_q(cke_q)
  );

  // A pending grant freezes new work so the bus is quiet when handed over
  assign req_ready = cmd_allowed && is_bus_master && !grant_pending;
  assign take = req_valid && req_ready;
  assign region_ok = !sdpc_needs_region(req_cmd) || sdpc_in_space(req_addr);
  assign issue = take && region_ok && (req_cmd != SDPC_CMD_NOP);
  assign is_write = (req_cmd == SDPC_CMD_WR);
  assign odd_word = req_addr[SDPC_ODD_WORD_POS];
  assign grant_safe = !in_suspend && !issue && (stb_q == SDPC_STB_NOP);

  always_comb
  begin
    sel_n_d = SDPC_SEL_N_RST;
    stb_d = SDPC_STB_NOP;
    low_word_data_mask_d = SDPC_MASK_RST;
    high_word_data_mask_d = SDPC_MASK_RST;
    a10_d = 1'b0;
    addr_d = addr_q;
    addr_oe_n_d = SDPC_OE_N_RST;
    drop_d = take && !region_ok;
    cmd_oe_n_d = !is_bus_master;
    cke_oe_n_d = !is_bus_master;
    if (issue)
    begin
      sel_n_d = 1'b0;
      stb_d = sdpc_encode(req_cmd);
      case (req_cmd)
        SDPC_CMD_ACT, SDPC_CMD_RD, SDPC_CMD_WR, SDPC_CMD_MRS:
        begin
          // Row or column goes out in the same edge as its strobe
          addr_d = req_sdram_addr;
          addr_oe_n_d = 1'b0;
          a10_d = req_sdram_addr[SDPC_A10_POS];
        end
        SDPC_CMD_PRE:
          a10_d = req_sdram_addr[SDPC_A10_POS];
        default:
          a10_d = 1'b0;
      endcase
      if (is_write)
      begin
        low_word_data_mask_d = !bus_is_32bit && odd_word && !req_long;
        high_word_data_mask_d = bus_is_32bit || (!req_long && !odd_word);
      end
      else
      begin
        low_word_data_mask_d = 1'b0;
        high_word_data_mask_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      sel_n_q <= SDPC_SEL_N_RST;
      stb_q <= SDPC_STB_NOP;
      low_word_data_mask_q <= SDPC_MASK_RST;
      high_word_data_mask_q <= SDPC_MASK_RST;
      a10_q <= 1'b0;
      addr_q <= '0;
      addr_oe_n_q <= SDPC_OE_N_RST;
      cmd_oe_n_q <= SDPC_OE_N_RST;
      cke_oe_n_q <= SDPC_OE_N_RST;
      drop_q <= 1'b0;
    end
    else
    begin
      sel_n_q <= sel_n_d;
      stb_q <= stb_d;
      low_word_data_mask_q <= low_word_data_mask_d;
      high_word_data_mask_q <= high_word_data_mask_d;
      a10_q <= a10_d;
      addr_q <= addr_d;
      addr_oe_n_q <= addr_oe_n_d;
      cmd_oe_n_q <= cmd_oe_n_d;
      cke_oe_n_q <= cke_oe_n_d;
      drop_q <= drop_d;
    end
  end

  assign sdram_space_select_n = sel_n_q;
  assign row_strobe_n = stb_q[2];
  assign col_strobe_n = stb_q[1];
  assign sdram_write_strobe_n = stb_q[0];
  assign low_word_data_mask = low_word_data_mask_q;
  assign high_word_data_mask = high_word_data_mask_q;
  assign dedicated_row_addr_bit10 = a10_q;
  assign sdram_addr = addr_q;
  assign sdram_addr_oe_n = addr_oe_n_q;
  assign cmd_pins_oe_n = cmd_oe_n_q;
  assign sdram_clock_enable_out = cke_q;
  assign cke_oe_n = cke_oe_n_q;
  assign req_dropped = drop_q;

  property p_space_select;
    @(posedge clk) disable iff (reset)
      (take && sdpc_needs_region(req_cmd) && sdpc_in_space(req_addr))
      |=> !sdram_space_select_n;
  endproperty
  a_space_select: assert property (p_space_select)
    else $error("space select missed on region access");

  property p_outside_region;
    @(posedge clk) disable iff (reset)
      (take && sdpc_needs_region(req_cmd) && !sdpc_in_space(req_addr))
      |=> sdram_space_select_n && row_strobe_n && col_strobe_n && req_dropped;
  endproperty
  a_outside_region: assert property (p_outside_region)
    else $error("command issued outside the SDRAM region");

  property p_not_master;
    @(posedge clk) disable iff (reset)
      !is_bus_master |=> cmd_pins_oe_n && cke_oe_n && sdram_addr_oe_n;
  endproperty
  a_not_master: assert property (p_not_master)
    else $error("pins driven while not bus master");

  property p_row_valid;
    @(posedge clk) disable iff (reset)
      (take && req_cmd == SDPC_CMD_ACT && region_ok)
      |=> !row_strobe_n && col_strobe_n && !sdram_addr_oe_n
          && sdram_addr == $past(req_sdram_addr);
  endproperty
  a_row_valid: assert property (p_row_valid)
    else $error("row strobe not aligned with row address");

  property p_col_read;
    @(posedge clk) disable iff (reset)
      (take && req_cmd == SDPC_CMD_RD && region_ok)
      |=> row_strobe_n && !col_strobe_n && sdram_write_strobe_n
          && sdram_addr == $past(req_sdram_addr) ##1 (col_strobe_n || $past(issue));
  endproperty
  a_col_read: assert property (p_col_read)
    else $error("read column cycle wrong");

  property p_refresh_code;
    @(posedge clk) disable iff (reset)
      (take && (req_cmd == SDPC_CMD_REF || req_cmd == SDPC_CMD_PRE))
      |=> !row_strobe_n && sdram_write_strobe_n != $past(req_cmd == SDPC_CMD_PRE)
          && (col_strobe_n == $past(req_cmd == SDPC_CMD_PRE));
  endproperty
  a_refresh_code: assert property (p_refresh_code)
    else $error("refresh or precharge strobe code wrong");

  property p_write_strobe;
    @(posedge clk) disable iff (reset)
      (take && req_cmd == SDPC_CMD_WR && region_ok)
      |=> !col_strobe_n && !sdram_write_strobe_n && row_strobe_n;
  endproperty
  a_write_strobe: assert property (p_write_strobe)
    else $error("write strobe not low on write column cycle");

  property p_mask_idle;
    @(posedge clk) disable iff (reset)
      (col_strobe_n || sdram_write_strobe_n) |-> !low_word_data_mask && !high_word_data_mask;
  endproperty
  a_mask_idle: assert property (p_mask_idle)
    else $error("mask active outside a write column cycle");

  property p_low_mask;
    @(posedge clk) disable iff (reset)
      (take && is_write && region_ok && !bus_is_32bit && !req_long)
      |=> low_word_data_mask == $past(odd_word) && high_word_data_mask == !$past(odd_word);
  endproperty
  a_low_mask: assert property (p_low_mask)
    else $error("word write masks wrong on 64-bit bus");

  property p_high_mask_32;
    @(posedge clk) disable iff (reset)
      (take && is_write && region_ok && bus_is_32bit)
      |=> high_word_data_mask && !low_word_data_mask;
  endproperty
  a_high_mask_32: assert property (p_high_mask_32)
    else $error("high mask not set on 32-bit bus write");

  property p_refresh_bus_free;
    @(posedge clk) disable iff (reset)
      (take && req_cmd == SDPC_CMD_REF) |=> sdram_addr_oe_n && !dedicated_row_addr_bit10;
  endproperty
  a_refresh_bus_free: assert property (p_refresh_bus_free)
    else $error("refresh used the shared address bus");

  property p_self_refresh;
    @(posedge clk) disable iff (reset)
      (take && req_cmd == SDPC_CMD_SR_ENTER)
      |=> !sdram_clock_enable_out && !row_strobe_n && !col_strobe_n ##1 !sdram_clock_enable_out;
  endproperty
  a_self_refresh: assert property (p_self_refresh)
    else $error("self-refresh entry did not drop clock enable");

  property p_suspend_cke;
    @(posedge clk) disable iff (reset)
      (take && req_cmd == SDPC_CMD_SUSP_ENTER) |=> !sdram_clock_enable_out;
  endproperty
  a_suspend_cke: assert property (p_suspend_cke)
    else $error("suspend entry did not drop clock enable");

  property p_exit_cke;
    @(posedge clk) disable iff (reset)
      (take && (req_cmd == SDPC_CMD_SR_EXIT || req_cmd == SDPC_CMD_SUSP_EXIT))
      |=> sdram_clock_enable_out;
  endproperty
  a_exit_cke: assert property (p_exit_cke)
    else $error("clock enable not raised on exit");

  property p_grant_rest;
    @(posedge clk) disable iff (reset)
      grant_pending |-> ##[0:2] (sdram_clock_enable_out == !in_self_refresh);
  endproperty
  a_grant_rest: assert property (p_grant_rest)
    else $error("clock enable not at rest level before grant");

  property p_quiet_nop;
    @(posedge clk) disable iff (reset)
      !issue |=> sdram_space_select_n && row_strobe_n && col_strobe_n && sdram_write_strobe_n;
  endproperty
  a_quiet_nop: assert property (p_quiet_nop)
    else $error("command pins changed without an accepted command");

endmodule // sdpc_pin_control

// *** test/sdpc_sdram_model.sv ***
// Purpose: Far-side SDRAM observer counting commands seen on the pins
// Assumes: Pins float high through pull-ups while not driven
// Notes: Only decodes, never answers; data lines are not modelled
module sdpc_sdram_model
(
  input wire logic clk,
  input wire logic reset,
  input wire logic oe_n,
  input wire logic sel_n,
  input wire logic row_n,
  input wire logic col_n,
  input wire logic we_n,
  output logic [7:0] cmd_count,
  output logic [2:0] last_code
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sel_pin;
  // Undriven select floats high, so a released bus issues nothing
  assign sel_pin = oe_n ? 1'b1 : sel_n;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmd_count <= 8'h00;
      last_code <= 3'h7;
    end
    else if (!sel_pin)
    begin
      cmd_count <= cmd_count + 8'h01;
      last_code <= {row_n, col_n, we_n};
    end
  end
endmodule // sdpc_sdram_model

// *** test/sdram_port_pin_control_bench.sv ***
// Purpose: Self-checking bench for the SDRAM pin control
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Every task starts and ends 1 ns after an edge
module sdram_port_pin_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import sdpc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic is_bus_master = 1'b0;
  logic grant_pending = 1'b0;
  logic bus_is_32bit = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready;
  sdpc_cmd_e req_cmd = SDPC_CMD_NOP;
  logic [31:0] req_addr = 32'h0;
  logic [SDPC_ADDR_W-1:0] req_sdram_addr = '0;
  logic req_long = 1'b0;
  logic req_dropped, grant_safe, sel_n, row_n, col_n, we_n, lmask, hmask, a10;
  logic [SDPC_ADDR_W-1:0] sdram_addr;
  logic addr_oe_n, pins_oe_n, cke, cke_oe_n;
  logic [7:0] cmd_count;
  logic [2:0] last_code;
  int errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  sdpc_pin_control DUT (.clk(clk), .reset(reset), .is_bus_master(is_bus_master),
    .grant_pending(grant_pending), .bus_is_32bit(bus_is_32bit), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_addr(req_addr),
    .req_sdram_addr(req_sdram_addr), .req_long(req_long), .req_dropped(req_dropped),
    .grant_safe(grant_safe), .sdram_space_select_n(sel_n), .row_strobe_n(row_n),
    .col_strobe_n(col_n), .sdram_write_strobe_n(we_n), .low_word_data_mask(lmask),
    .high_word_data_mask(hmask), .dedicated_row_addr_bit10(a10), .sdram_addr(sdram_addr),
    .sdram_addr_oe_n(addr_oe_n), .cmd_pins_oe_n(pins_oe_n),
    .sdram_clock_enable_out(cke), .cke_oe_n(cke_oe_n));
  sdpc_sdram_model mem (.clk(clk), .reset(reset), .oe_n(pins_oe_n), .sel_n(sel_n),
    .row_n(row_n), .col_n(col_n), .we_n(we_n), .cmd_count(cmd_count),
    .last_code(last_code));
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    req_valid = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Holds the request until the edge that samples ready high
  // Valid stays up on return; the next issue or idle takes it over in that step
  task automatic issue(input sdpc_cmd_e c, input logic [31:0] a, input logic [13:0] s,
    input logic lg);
    int n;
    n = 0;
    req_cmd = c;
    req_addr = a;
    req_sdram_addr = s;
    req_long = lg;
    req_valid = 1'b1;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check("taken", n < 20, 1'b1);
    @(posedge clk);
    #1;
  endtask
  task automatic t_reset_and_master();
    check("sel_n rst", sel_n, 1'b1);
    check("masks rst", {lmask, hmask}, 2'b00);
    check("oe rst", {pins_oe_n, cke_oe_n, cke}, 3'b111);
    check("ready slave", req_ready, 1'b0);
    is_bus_master = 1'b1;
    idle(2);
    check("oe master", {pins_oe_n, cke_oe_n}, 2'b00);
  endtask
  task automatic t_commands();
    sdpc_cmd_e cl[6];
    logic [2:0] ex[6];
    cl = '{SDPC_CMD_ACT, SDPC_CMD_RD, SDPC_CMD_WR, SDPC_CMD_PRE, SDPC_CMD_REF, SDPC_CMD_MRS};
    ex = '{3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
    // Back to back, one per cycle
    for (int i = 0; i < 6; i++)
    begin
      issue(cl[i], 32'h0400_0000, 14'h0400, 1'b0);
      check("strobes", {row_n, col_n, we_n}, ex[i]);
      check("sel_n", sel_n, 1'b0);
      check("a10", a10, cl[i] != SDPC_CMD_REF);
      check("addr", sdram_addr, 14'h0400);
      check("addr oe", addr_oe_n, cl[i] == SDPC_CMD_PRE || cl[i] == SDPC_CMD_REF);
    end
    idle(1);
    check("nop", {sel_n, row_n, col_n, we_n}, 4'hf);
    check("grant safe", grant_safe, 1'b1);
  endtask
  task automatic t_masks();
    logic [31:0] ad[5];
    logic [4:0] b32, lg, wr;
    logic [1:0] ex[5];
    ad = '{32'h0400_0001, 32'h0400_0000, 32'h0400_0002, 32'h0400_0001, 32'h0400_0001};
    b32 = 5'b01000;
    lg = 5'b00100;
    wr = 5'b01111;
    ex = '{2'b10, 2'b01, 2'b00, 2'b01, 2'b00};
    for (int i = 0; i < 5; i++)
    begin
      bus_is_32bit = b32[i];
      issue(wr[i] ? SDPC_CMD_WR : SDPC_CMD_RD, ad[i], 14'h0011, lg[i]);
      check("masks", {lmask, hmask}, ex[i]);
      check("we_n", we_n, !wr[i]);
    end
    bus_is_32bit = 1'b0;
    idle(1);
    check("masks idle", {lmask, hmask}, 2'b00);
  endtask
  task automatic t_outside();
    issue(SDPC_CMD_RD, 32'h0800_0000, 14'h0022, 1'b0);
    check("sel_n out", sel_n, 1'b1);
    check("dropped", req_dropped, 1'b1);
    idle(1);
    check("dropped end", req_dropped, 1'b0);
    check("mem count", cmd_count, 8'd11);
    check("mem last", last_code, 3'h5);
  endtask
  task automatic t_self_refresh();
    issue(SDPC_CMD_SR_ENTER, 32'h0, 14'h0, 1'b0);
    check("sr code", {sel_n, row_n, col_n, we_n}, 4'h1);
    check("sr cke", cke, 1'b0);
    check("sr ready", req_ready, 1'b0);
    grant_pending = 1'b1;
    idle(3);
    check("sr grant cke", cke, 1'b0);
    grant_pending = 1'b0;
    issue(SDPC_CMD_SR_EXIT, 32'h0, 14'h0, 1'b0);
    idle(1);
    check("sr exit cke", cke, 1'b1);
  endtask
  task automatic t_suspend();
    issue(SDPC_CMD_SUSP_ENTER, 32'h0, 14'h0, 1'b0);
    check("susp cke", cke, 1'b0);
    check("susp nop", {sel_n, row_n, col_n, we_n}, 4'h7);
    check("susp unsafe", grant_safe, 1'b0);
    grant_pending = 1'b1;
    idle(2);
    check("grant cke", cke, 1'b1);
    check("grant ready", req_ready, 1'b0);
    grant_pending = 1'b0;
    issue(SDPC_CMD_SUSP_ENTER, 32'h0, 14'h0, 1'b0);
    issue(SDPC_CMD_SUSP_EXIT, 32'h0, 14'h0, 1'b0);
    check("susp exit cke", cke, 1'b1);
  endtask
  task automatic t_release();
    is_bus_master = 1'b0;
    idle(2);
    check("released", {pins_oe_n, cke_oe_n, req_ready}, 3'b110);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    reset = 1'b0;
    t_reset_and_master();
    t_commands();
    t_masks();
    t_outside();
    t_self_refresh();
    t_suspend();
    t_release();
    stop_test();
  end
  // Whole run needs under 200 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      stop_test();
    end
  end
endmodule // sdram_port_pin_control_bench
